// ==== bench/pafc_host.sv ====
// host controller model issuing register accesses
`timescale 1ns/100ps
`default_nettype none
module pafc_host
    import pafc_pkg::*;
(
    input  wire logic       clk_in,    // clock
    input  wire logic [7:0] rdata_in,  // read data
    input  wire logic       rvalid_in, // read valid
    output var pafc_req_s   req_out    // access
);
    initial req_out = '0;
    // one strobe cycle; data only counts while valid
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_in);
        req_out <= '0;
        #1;
        q = rvalid_in ? rdata_in : 8'hxx;
    endtask
endmodule // pafc_host
`default_nettype wire

// ==== bench/pafc_regs_chk.sv ====
// port assertions for the register bank
`timescale 1ns/100ps
`default_nettype none
module pafc_regs_chk
    import pafc_pkg::*;
(
    input wire logic        core_clk_in,      // clock
    input wire logic        reset_in,         // reset
    input wire pafc_req_s   req_in,           // access
    input wire pafc_fault_s fault_in,         // events
    input wire logic        wake_in,          // wake
    input wire logic [7:0]  rdata_out,        // data
    input wire logic        rvalid_out,       // valid
    input wire logic        charge_sw_out,    // charge
    input wire logic        discharge_sw_out, // discharge
    input wire logic [7:1]  balance_out,      // balance
    input wire logic        regulator_on_out, // regulator
    input wire logic        load_monitor_out, // monitor
    input wire logic [3:0]  monitor_sel_out,  // code
    input wire logic        sleep_out         // asleep
);
    // ------
    // auto-disable copies: charge oc, discharge oc, short
    // ------
    logic [2:0] dis_q;
    wire logic  fw = req_in.wr && req_in.addr == PAFC_ADDR_FET;
    wire logic  aw = req_in.wr && req_in.addr == PAFC_ADDR_ANALOG;
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            dis_q <= 3'h0;
        else if (req_in.wr && req_in.addr == PAFC_ADDR_DSCHG)
            dis_q[1:0] <= {req_in.wdata[7], req_in.wdata[4]};
        else if (req_in.wr && req_in.addr == PAFC_ADDR_CHG)
            dis_q[2] <= req_in.wdata[7];
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_sleep_cmd; fw && req_in.wdata[7]; endsequence
    sequence s_off; !regulator_on_out && !charge_sw_out && !discharge_sw_out && balance_out == 7'h00; endsequence
    property p_sleep; s_sleep_cmd |=> sleep_out ##0 s_off; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
    property p_hold; sleep_out |-> s_off; endproperty
    a_hold: assert property (p_hold) else $error("drives on while asleep");
    property p_wake; sleep_out && wake_in && !fw |=> !sleep_out && regulator_on_out; endproperty
    a_wake: assert property (p_wake) else $error("wake did not clear sleep");
    property p_keep; sleep_out && !req_in.wr |=> $stable(monitor_sel_out) && $stable(load_monitor_out); endproperty
    a_keep: assert property (p_keep) else $error("settings lost in sleep");
    property p_lmon; fw |=> load_monitor_out == $past(req_in.wdata[6]); endproperty
    a_lmon: assert property (p_lmon) else $error("load monitor wrong");
    property p_sw;
        fw && !req_in.wdata[7] && fault_in == 3'h0 |=>
            charge_sw_out == $past(req_in.wdata[1]) && discharge_sw_out == $past(req_in.wdata[0]);
    endproperty
    a_sw: assert property (p_sw) else $error("switch drive wrong");
    property p_coc; fault_in.charge_oc && !dis_q[2] |=> !charge_sw_out; endproperty
    a_coc: assert property (p_coc) else $error("charge oc not cleared");
    property p_doc;
        fault_in.discharge_oc && !dis_q[1] || fault_in.discharge_short && !dis_q[0] |=> !discharge_sw_out;
    endproperty
    a_doc: assert property (p_doc) else $error("discharge fault not cleared");
    property p_sel;
        aw |=> monitor_sel_out == ($past(req_in.wdata[3:0]) > 4'h9 ? 4'h0 : $past(req_in.wdata[3:0]));
    endproperty
    a_sel: assert property (p_sel) else $error("monitor code wrong");
    property p_rsv; req_in.rd && req_in.addr == PAFC_ADDR_FET |=> rvalid_out && rdata_out[5:2] == 4'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
endmodule // pafc_regs_chk
bind pafc_regs pafc_regs_chk i_chk (.core_clk_in, .reset_in, .req_in, .fault_in, .wake_in, .rdata_out,
    .rvalid_out, .charge_sw_out, .discharge_sw_out, .balance_out, .regulator_on_out, .load_monitor_out,
    .monitor_sel_out, .sleep_out);
`default_nettype wire

// ==== bench/pafc_regs_tb_top.sv ====
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module pafc_regs_tb_top;
    import pafc_pkg::*;
    logic        clk, rst, wake, rv, cs, ds, ro, lm, sl;
    pafc_fault_s flt;
    pafc_req_s   req;
    logic [7:0]  rdata, q, r;
    logic [7:1]  bal;
    logic [3:0]  sel;
    logic [7:0]  m [8] = '{default: 8'h00};
    logic [7:0]  mk [8] = '{8'h00, 8'h00, PAFC_MASK_BALANCE, PAFC_MASK_ANALOG, PAFC_MASK_FET, PAFC_MASK_DSCHG,
                            PAFC_MASK_CHG, 8'h00};
    int          fail_count = 0;
    int          n_checks = 0;
    pafc_regs i_pafc_regs (.core_clk_in(clk), .reset_in(rst), .req_in(req), .fault_in(flt), .wake_in(wake),
        .rdata_out(rdata), .rvalid_out(rv), .charge_sw_out(cs), .discharge_sw_out(ds), .balance_out(bal),
        .regulator_on_out(ro), .load_monitor_out(lm), .monitor_sel_out(sel), .sleep_out(sl));
    pafc_host i_pafc_host (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rv), .req_out(req));
    // ------
    // model and checks
    // ------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic outs();
        chk("switches", {6'h0, m[4][1:0]}, {6'h0, cs, ds});
        chk("balance", m[2], {bal, 1'b0});
        chk("sleep", {6'h0, m[4][7], !m[4][7]}, {6'h0, sl, ro});
        chk("monitor", {3'h0, m[4][6], m[3][3:0] > 4'h9 ? 4'h0 : m[3][3:0]}, {3'h0, lm, sel});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_pafc_host.access(1'b1, a, d, q);
        m[a[2:0]] = d & mk[a[2:0]];
        if (m[4][7])
        begin
            m[4][1:0] = 2'h0;
            m[2] = 8'h00;
        end
        outs();
    endtask
    task automatic rd(input logic [7:0] a);
        i_pafc_host.access(1'b0, a, 8'h00, q);
        chk("read", a > 8'h07 ? 8'h00 : m[a[2:0]], q);
    endtask
    task automatic ev(input pafc_fault_s f, input logic w);
        @(posedge clk);
        flt <= f;
        wake <= w;
        @(posedge clk);
        flt <= '0;
        wake <= 1'b0;
        #1;
        if (w) m[4][7] = 1'b0;
        if (f.charge_oc && !m[6][7]) m[4][1] = 1'b0;
        if (f.discharge_oc && !m[5][7] || f.discharge_short && !m[5][4]) m[4][0] = 1'b0;
        outs();
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    initial
    begin
        int i;
        int j;
        rst = 1'b1;
        wake = 1'b0;
        flt = '0;
        i = $urandom(96);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++)
            rd(i[7:0]);
        rd(8'h3c);
        outs();
        $display("test reset done");
        for (i = 0; i < 16; i++)
        begin
            r = $urandom;
            wr(PAFC_ADDR_ANALOG, {r[7:4], i[3:0]});
            rd(PAFC_ADDR_ANALOG);
        end
        $display("test monitor codes done");
        wr(PAFC_ADDR_ANALOG, 8'hc5);
        wr(PAFC_ADDR_FET, 8'h43);
        wr(PAFC_ADDR_BALANCE, 8'hff);
        wr(PAFC_ADDR_FET, 8'hc3);
        wr(PAFC_ADDR_BALANCE, 8'h0e);
        rd(PAFC_ADDR_ANALOG);
        ev(3'h0, 1'b1);
        rd(PAFC_ADDR_FET);
        $display("test sleep done");
        for (i = 0; i < 8; i++)
        begin
            wr(PAFC_ADDR_DSCHG, {i[1], 2'h0, i[0], 4'h0});
            wr(PAFC_ADDR_CHG, {i[2], 7'h0});
            for (j = 0; j < 3; j++)
            begin
                wr(PAFC_ADDR_FET, 8'h03);
                ev(3'h1 << j, 1'b0);
            end
        end
        $display("test faults done");
        for (i = 0; i < 300; i++)
        begin
            r = $urandom;
            j = $urandom;
            if (r[1:0] == 2'h0)
                ev(j[2:0], j[3]);
            else if (r[1])
                wr({5'h0, j[2:0]}, j[15:8]);
            else
                rd({5'h0, j[2:0]});
        end
        $display("test random done");
        finish_test();
    end
endmodule // pafc_regs_tb_top
`default_nettype wire

// ==== logic/pafc_regs.sv ====
// control register bank for analog-output routing, sleep and switch enables
`timescale 1ns/100ps
`default_nettype none

module pafc_regs
    import pafc_pkg::*;
(
    input  wire logic        core_clk_in,      // 50 MHz clock
    input  wire logic        reset_in,         // synchronous, active high
    input  wire pafc_req_s   req_in,           // register access request
    input  wire pafc_fault_s fault_in,         // protection event pulses
    input  wire logic        wake_in,          // wake event pulse
    output logic [7:0]       rdata_out,        // read data
    output logic             rvalid_out,       // read data valid pulse
    output logic             charge_sw_out,    // charge switch drive
    output logic             discharge_sw_out, // discharge switch drive
    output logic [7:1]       balance_out,      // cell balance drives
    output logic             regulator_on_out, // regulator output enable
    output logic             load_monitor_out, // load voltage monitor enable
    output logic [3:0]       monitor_sel_out,  // routed monitor code
    output logic             sleep_out         // device asleep
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] balance_q, balance_d;
    logic [7:0] analog_q,  analog_d;
    logic [7:0] fet_q,     fet_d;
    logic [7:0] dschg_q,   dschg_d;
    logic [7:0] chg_q,     chg_d;

    function automatic logic hit(input pafc_req_s r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] wd, input logic [7:0] mask);
        merge = wd & mask;
    endfunction

    always_comb
    begin
        balance_d = balance_q;
        analog_d  = analog_q;
        fet_d     = fet_q;
        dschg_d   = dschg_q;
        chg_d     = chg_q;

        // software writes
        if (hit(req_in, PAFC_ADDR_BALANCE))
        begin
            balance_d = merge(req_in.wdata, PAFC_MASK_BALANCE);
        end
        if (hit(req_in, PAFC_ADDR_ANALOG))
        begin
            analog_d = merge(req_in.wdata, PAFC_MASK_ANALOG);
        end
        if (hit(req_in, PAFC_ADDR_FET))
        begin
            fet_d = merge(req_in.wdata, PAFC_MASK_FET);
        end
        if (hit(req_in, PAFC_ADDR_DSCHG))
        begin
            dschg_d = merge(req_in.wdata, PAFC_MASK_DSCHG);
        end
        if (hit(req_in, PAFC_ADDR_CHG))
        begin
            chg_d = merge(req_in.wdata, PAFC_MASK_CHG);
        end

        // wake clears force-sleep unless software sets it in the same cycle
        if (wake_in && !(hit(req_in, PAFC_ADDR_FET) && req_in.wdata[PAFC_BIT_FORCE_SLEEP]))
        begin
            fet_d[PAFC_BIT_FORCE_SLEEP] = 1'b0;
        end

        // hardware protection overrides a simultaneous software set
        if (fault_in.charge_oc && !chg_q[PAFC_BIT_CHG_OC_AUTO_DIS])
        begin
            fet_d[PAFC_BIT_CHARGE_SW] = 1'b0;
        end
        if ((fault_in.discharge_oc && !dschg_q[PAFC_BIT_DSCHG_OC_AUTO_DIS]) ||
            (fault_in.discharge_short && !dschg_q[PAFC_BIT_SHORT_AUTO_DIS]))
        begin
            fet_d[PAFC_BIT_DISCHARGE_SW] = 1'b0;
        end

        // forced sleep clears switch and balance enables, keeps select and flags
        if (fet_d[PAFC_BIT_FORCE_SLEEP])
        begin
            fet_d[PAFC_BIT_CHARGE_SW]    = 1'b0;
            fet_d[PAFC_BIT_DISCHARGE_SW] = 1'b0;
            balance_d                    = 8'h00;
        end
    end

    // sleep leaves every register except the cleared enables untouched
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            balance_q <= PAFC_RST_BALANCE;
            analog_q  <= PAFC_RST_ANALOG;
            fet_q     <= PAFC_RST_FET;
            dschg_q   <= PAFC_RST_DSCHG;
            chg_q     <= PAFC_RST_CHG;
        end
        else
        begin
            balance_q <= balance_d;
            analog_q  <= analog_d;
            fet_q     <= fet_d;
            dschg_q   <= dschg_d;
            chg_q     <= chg_d;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;

    always_comb
    begin
        rvalid_d = req_in.rd;
        rdata_d  = 8'h00;
        if (req_in.rd)
        begin
            case (req_in.addr)
                PAFC_ADDR_BALANCE: rdata_d = balance_q & PAFC_MASK_BALANCE;
                PAFC_ADDR_ANALOG:  rdata_d = analog_q & PAFC_MASK_ANALOG;
                PAFC_ADDR_FET:     rdata_d = fet_q & PAFC_MASK_FET;
                PAFC_ADDR_DSCHG:   rdata_d = dschg_q & PAFC_MASK_DSCHG;
                PAFC_ADDR_CHG:     rdata_d = chg_q & PAFC_MASK_CHG;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ----------------------------------------------------------------
    // output drives
    // ----------------------------------------------------------------
    logic       chg_sw_q, chg_sw_d;
    logic       dis_sw_q, dis_sw_d;
    logic [7:1] bal_q,    bal_d;
    logic       reg_on_q, reg_on_d;
    logic       ldmon_q,  ldmon_d;
    logic [3:0] mon_q,    mon_d;
    logic       sleep_q,  sleep_d;

    always_comb
    begin
        sleep_d  = fet_d[PAFC_BIT_FORCE_SLEEP];
        reg_on_d = !sleep_d;
        chg_sw_d = fet_d[PAFC_BIT_CHARGE_SW] && !sleep_d;
        dis_sw_d = fet_d[PAFC_BIT_DISCHARGE_SW] && !sleep_d;
        bal_d    = sleep_d ? 7'h00 : balance_d[7:1];
        ldmon_d  = fet_d[PAFC_BIT_LOAD_MON];
        case (analog_d[3:0])
            PAFC_MON_NONE:     mon_d = PAFC_MON_NONE;
            PAFC_MON_EXT_TEMP: mon_d = PAFC_MON_EXT_TEMP;
            PAFC_MON_INT_TEMP: mon_d = PAFC_MON_INT_TEMP;
            default:
            begin
                if (analog_d[3:0] <= PAFC_MON_CELL7)
                begin
                    mon_d = analog_d[3:0];
                end
                else
                begin
                    mon_d = PAFC_MON_NONE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            chg_sw_q <= 1'b0;
            dis_sw_q <= 1'b0;
            bal_q    <= 7'h00;
            reg_on_q <= 1'b1;
            ldmon_q  <= 1'b0;
            mon_q    <= PAFC_MON_NONE;
            sleep_q  <= 1'b0;
        end
        else
        begin
            chg_sw_q <= chg_sw_d;
            dis_sw_q <= dis_sw_d;
            bal_q    <= bal_d;
            reg_on_q <= reg_on_d;
            ldmon_q  <= ldmon_d;
            mon_q    <= mon_d;
            sleep_q  <= sleep_d;
        end
    end

    assign rdata_out        = rdata_q;
    assign rvalid_out       = rvalid_q;
    assign charge_sw_out    = chg_sw_q;
    assign discharge_sw_out = dis_sw_q;
    assign balance_out      = bal_q;
    assign regulator_on_out = reg_on_q;
    assign load_monitor_out = ldmon_q;
    assign monitor_sel_out  = mon_q;
    assign sleep_out        = sleep_q;

endmodule // pafc_regs

`default_nettype wire

// ==== pkg/pafc_pkg.sv ====
// constants and types for the pack analog-output and switch control register bank
package pafc_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PAFC_ADDR_BALANCE  = 8'h02;
    localparam logic [7:0] PAFC_ADDR_ANALOG   = 8'h03;
    localparam logic [7:0] PAFC_ADDR_FET      = 8'h04;
    localparam logic [7:0] PAFC_ADDR_DSCHG    = 8'h05;
    localparam logic [7:0] PAFC_ADDR_CHG      = 8'h06;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PAFC_BIT_USER_FLAG_HIGH    = 7;
    localparam int PAFC_BIT_USER_FLAG_LOW     = 6;
    localparam int PAFC_BIT_FORCE_SLEEP       = 7;
    localparam int PAFC_BIT_LOAD_MON          = 6;
    localparam int PAFC_BIT_CHARGE_SW         = 1;
    localparam int PAFC_BIT_DISCHARGE_SW      = 0;
    localparam int PAFC_BIT_DSCHG_OC_AUTO_DIS = 7;
    localparam int PAFC_BIT_SHORT_AUTO_DIS    = 4;
    localparam int PAFC_BIT_CHG_OC_AUTO_DIS   = 7;

    // writable bit masks, reserved bits read zero
    localparam logic [7:0] PAFC_MASK_BALANCE  = 8'hfe;
    localparam logic [7:0] PAFC_MASK_ANALOG   = 8'hcf;
    localparam logic [7:0] PAFC_MASK_FET      = 8'hc3;
    localparam logic [7:0] PAFC_MASK_DSCHG    = 8'hff;
    localparam logic [7:0] PAFC_MASK_CHG      = 8'h80;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] PAFC_RST_BALANCE   = 8'h00;
    localparam logic [7:0] PAFC_RST_ANALOG    = 8'h00;
    localparam logic [7:0] PAFC_RST_FET       = 8'h00;
    localparam logic [7:0] PAFC_RST_DSCHG     = 8'h00;
    localparam logic [7:0] PAFC_RST_CHG       = 8'h00;

    // ----------------------------------------------------------------
    // monitor select codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        PAFC_MON_NONE     = 4'h0,
        PAFC_MON_CELL1    = 4'h1,
        PAFC_MON_CELL7    = 4'h7,
        PAFC_MON_EXT_TEMP = 4'h8,
        PAFC_MON_INT_TEMP = 4'h9
    } pafc_mon_e;

    // register access request from the serial interface engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pafc_req_s;

    // protection events, one-cycle pulses
    typedef struct packed {
        logic charge_oc;
        logic discharge_oc;
        logic discharge_short;
    } pafc_fault_s;

endpackage
